// File: hdl/msr_regs.sv
`timescale 1ns/1ps

module msr_regs
    import msr_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // clock and reset
    input logic hclk,
    input logic hresetn,
    // ahb-lite slave
    input logic hsel,
    input logic [AW-1:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // sensor side
    input msr_evt_t evt,
    input logic sample_valid,
    input msr_sample_t sample,
    // digital path restarts and interrupt line
    output msr_path_rst_t path_rst,
    output logic irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] word_pos(input logic [7:0] idx);
        logic [7:0] rel;
        rel = idx - IDX_ACCEL_X_HI;
        word_pos = 3'(NUM_WORDS - 1) - rel[3:1];
    endfunction

    function automatic logic is_hi(input logic [7:0] idx);
        logic [7:0] rel;
        rel = idx - IDX_ACCEL_X_HI;
        is_hi = ~rel[0];
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    msr_phase_t phase_r;
    logic [7:0] wr_idx_r;
    logic [7:0] flags_r;
    logic [7:0] irq_en_r;
    logic [7:0] pin_cfg_r;
    logic [NUM_WORDS-1:0][15:0] sample_r;
    logic [NUM_WORDS-1:0][7:0] shadow_r;
    logic [NUM_WORDS-1:0] shadow_vld_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    msr_path_rst_t path_rst_r;
    logic irq_r;

    // ----------------------------------------------------------------
    // address phase decode
    // ----------------------------------------------------------------
    wire take = hsel & htrans[1] & hready;
    wire rd_take = take & ~hwrite;
    wire wr_take = take & hwrite;
    wire addr_ok = (haddr[1:0] == 2'b00) && (haddr[AW-1:10] == '0);
    wire [7:0] rd_idx = addr_ok ? haddr[9:2] : IDX_NONE;
    wire rd_sample = (rd_idx >= IDX_ACCEL_X_HI) && (rd_idx <= IDX_RATE_Z_LO);
    wire rd_hi = is_hi(rd_idx);
    wire [2:0] rd_pos = word_pos(rd_idx);
    wire [15:0] rd_word = rd_sample ? sample_r[rd_pos] : RST_SAMPLE;
    wire [7:0] rd_shadow = rd_sample ? shadow_r[rd_pos] : 8'h00;
    wire rd_shadow_vld = rd_sample & shadow_vld_r[rd_pos];

    // a low byte read after its high byte returns the byte captured with it
    wire [7:0] rd_lo = rd_shadow_vld ? rd_shadow : rd_word[7:0];
    wire [7:0] rd_sample_byte = rd_hi ? rd_word[15:8] : rd_lo;
    wire [7:0] rd_byte =
        (rd_idx == IDX_IRQ_FLAGS) ? flags_r :
        (rd_idx == IDX_IRQ_ENABLE) ? irq_en_r :
        (rd_idx == IDX_PIN_CFG) ? pin_cfg_r :
        rd_sample ? rd_sample_byte :
        8'h00;
    wire [31:0] hrdata_nxt = rd_take ? {24'h000000, rd_byte} : hrdata_r;

    // ----------------------------------------------------------------
    // data phase writes
    // ----------------------------------------------------------------
    wire wr_now = (phase_r == PH_WDATA);
    wire [7:0] wr_byte = hwdata[7:0];
    wire wr_en_reg = wr_now && (wr_idx_r == IDX_IRQ_ENABLE);
    wire wr_pin_cfg = wr_now && (wr_idx_r == IDX_PIN_CFG);
    wire wr_restart = wr_now && (wr_idx_r == IDX_PATH_RESTART);
    wire full_clr = wr_now && (wr_idx_r == IDX_USER_CTRL) && wr_byte[BIT_FULL_CLR];
    msr_phase_t phase_nxt;
    assign phase_nxt = wr_take ? PH_WDATA : PH_ADDR;
    wire [7:0] wr_idx_nxt = wr_take ? (addr_ok ? haddr[9:2] : IDX_NONE) : wr_idx_r;
    // status and sample indices simply have no write decode
    wire [7:0] irq_en_nxt = wr_en_reg ? (wr_byte & IRQ_FLAGS_MASK) : irq_en_r;
    wire [7:0] pin_cfg_nxt = wr_pin_cfg ? (wr_byte & PIN_CFG_MASK) : pin_cfg_r;

    // only bits 2..0 are looked at; a full clear restarts all three paths
    msr_path_rst_t path_rst_nxt;
    assign path_rst_nxt.rate = (wr_restart & wr_byte[BIT_RATE_RST]) | full_clr;
    assign path_rst_nxt.accel = (wr_restart & wr_byte[BIT_ACCEL_RST]) | full_clr;
    assign path_rst_nxt.temp = (wr_restart & wr_byte[BIT_TEMP_RST]) | full_clr;

    // ----------------------------------------------------------------
    // interrupt flags
    // ----------------------------------------------------------------
    wire any_read_clr = pin_cfg_r[BIT_ANY_READ_CLR];
    wire flag_clr = rd_take & ((rd_idx == IDX_IRQ_FLAGS) | any_read_clr);
    wire [7:0] flag_set = {
        evt.wake_x,
        evt.wake_y,
        evt.wake_z,
        evt.buf_overflow,
        1'b0,
        evt.drive_ready,
        evt.proc_irq,
        sample_valid
    };
    // a set in the clearing cycle survives, so no event is lost
    wire [7:0] flags_nxt = ((flags_r & ~{8{flag_clr}}) | flag_set) & IRQ_FLAGS_MASK;
    wire irq_nxt = |(flags_r & irq_en_r);

    // ----------------------------------------------------------------
    // sample words
    // ----------------------------------------------------------------
    wire [NUM_WORDS-1:0][15:0] sample_in = sample;
    // path restarts never touch the words; only the full clear does
    wire [NUM_WORDS-1:0][15:0] sample_nxt =
        full_clr ? '0 : (sample_valid ? sample_in : sample_r);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= PH_ADDR;
            wr_idx_r <= IDX_NONE;
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            wr_idx_r <= wr_idx_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= RST_IRQ_FLAGS;
            irq_en_r <= RST_IRQ_ENABLE;
            pin_cfg_r <= RST_PIN_CFG;
            path_rst_r <= '0;
            irq_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            irq_en_r <= irq_en_nxt;
            pin_cfg_r <= pin_cfg_nxt;
            path_rst_r <= path_rst_nxt;
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_r <= '0;
        end else begin
            sample_r <= sample_nxt;
        end
    end

    // the capture happens on the high byte read so a new sample between
    // the two reads cannot tear the pair
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shadow_r <= '0;
            shadow_vld_r <= '0;
        end else if (full_clr) begin
            shadow_r <= '0;
            shadow_vld_r <= '0;
        end else if (rd_take && rd_sample && rd_hi) begin
            shadow_r[rd_pos] <= rd_word[7:0];
            shadow_vld_r[rd_pos] <= 1'b1;
        end else if (rd_take && rd_sample) begin
            shadow_vld_r[rd_pos] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign path_rst = path_rst_r;
    assign irq = irq_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_restart_write;
        wr_now && (wr_idx_r == IDX_PATH_RESTART);
    endsequence

    sequence s_status_read;
        rd_take && (rd_idx == IDX_IRQ_FLAGS) && (flag_set == 8'h00);
    endsequence

    property p_wake_flags;
        evt.wake_x && evt.wake_y && evt.wake_z |=> flags_r[7:5] == 3'b111;
    endproperty
    a_wake_flags: assert property (p_wake_flags) else $error("wake flags not set");

    property p_overflow_flag;
        evt.buf_overflow |=> flags_r[BIT_OVERFLOW];
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag lost");

    property p_drive_flag;
        evt.drive_ready |=> flags_r[BIT_DRIVE_RDY] ##1 (flags_r[BIT_DRIVE_RDY] || $past(flag_clr));
    endproperty
    a_drive_flag: assert property (p_drive_flag) else $error("drive flag not held");

    property p_proc_flag;
        evt.proc_irq |=> flags_r[BIT_PROC_IRQ];
    endproperty
    a_proc_flag: assert property (p_proc_flag) else $error("processor flag lost");

    property p_raw_flag;
        sample_valid && flag_clr |=> flags_r[BIT_RAW_RDY];
    endproperty
    a_raw_flag: assert property (p_raw_flag) else $error("raw flag lost on clear");

    property p_resvd_flag;
        flags_r[BIT_FLAG_RESVD] == 1'b0;
    endproperty
    a_resvd_flag: assert property (p_resvd_flag) else $error("reserved flag set");

    property p_sample_load;
        sample_valid && !full_clr |=> sample_r == $past(sample_in);
    endproperty
    a_sample_load: assert property (p_sample_load) else $error("sample not loaded");

    property p_status_clear;
        s_status_read |=> (flags_r == 8'h00) && (hrdata_r[7:0] == $past(flags_r));
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared");

    property p_any_read;
        rd_take && any_read_clr && (flag_set == 8'h00) |=> flags_r == 8'h00;
    endproperty
    a_any_read: assert property (p_any_read) else $error("any read did not clear");

    property p_rate_restart;
        s_restart_write ##0 hwdata[BIT_RATE_RST] |=> path_rst_r.rate;
    endproperty
    a_rate_restart: assert property (p_rate_restart) else $error("rate restart missing");

    property p_keep_samples;
        s_restart_write ##0 !sample_valid |=> $stable(sample_r);
    endproperty
    a_keep_samples: assert property (p_keep_samples) else $error("samples changed");

    property p_full_clear;
        full_clr |=> (sample_r == '0) && (path_rst_r == 3'b111);
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("full clear incomplete");

    property p_irq_gate;
        ##1 irq_r == |($past(flags_r) & $past(irq_en_r));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

    property p_restart_reads_zero;
        rd_take && (rd_idx == IDX_PATH_RESTART) |=> hrdata_r == 32'h00000000;
    endproperty
    a_restart_reads_zero: assert property (p_restart_reads_zero)
        else $error("restart read not zero");

    property p_accel_restart;
        s_restart_write ##0 hwdata[BIT_ACCEL_RST] |=> path_rst_r.accel;
    endproperty
    a_accel_restart: assert property (p_accel_restart) else $error("accel restart lost");

    property p_temp_restart;
        s_restart_write ##0 hwdata[BIT_TEMP_RST] |=> path_rst_r.temp;
    endproperty
    a_temp_restart: assert property (p_temp_restart) else $error("temp restart lost");

    property p_resvd_restart;
        s_restart_write ##0 (hwdata[2:0] == 3'b000) |=> path_rst_r == 3'b000;
    endproperty
    a_resvd_restart: assert property (p_resvd_restart) else $error("reserved restart");

    // a restart bit left high would hold its path in reset for good
    property p_restart_pulse;
        (|path_rst_r) && !wr_restart && !full_clr |=> path_rst_r == 3'b000;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart stuck");

    property p_ignored_write;
        wr_now && (wr_idx_r == IDX_IRQ_FLAGS) && !flag_clr && (flag_set == 8'h00)
            |=> $stable(flags_r);
    endproperty
    a_ignored_write: assert property (p_ignored_write) else $error("status write acted");

    // a clear keeps only what was set in the same cycle
    property p_clr_keeps_set;
        flag_clr |=> flags_r == ($past(flag_set) & IRQ_FLAGS_MASK);
    endproperty
    a_clr_keeps_set: assert property (p_clr_keeps_set) else $error("clear lost a set");

    property p_sample_hold;
        !sample_valid && !full_clr |=> $stable(sample_r);
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("sample drifted");

endmodule

// File: hdl/msr_pkg.sv
package msr_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int NUM_WORDS = 7;

    // ----------------------------------------------------------------
    // register indices; the byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_PIN_CFG = 8'h37;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h38;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h3a;
    localparam logic [7:0] IDX_ACCEL_X_HI = 8'h3b;
    localparam logic [7:0] IDX_ACCEL_X_LO = 8'h3c;
    localparam logic [7:0] IDX_ACCEL_Y_HI = 8'h3d;
    localparam logic [7:0] IDX_ACCEL_Y_LO = 8'h3e;
    localparam logic [7:0] IDX_ACCEL_Z_HI = 8'h3f;
    localparam logic [7:0] IDX_ACCEL_Z_LO = 8'h40;
    localparam logic [7:0] IDX_TEMPERATURE_HI = 8'h41;
    localparam logic [7:0] IDX_TEMPERATURE_LO = 8'h42;
    localparam logic [7:0] IDX_RATE_X_HI = 8'h43;
    localparam logic [7:0] IDX_RATE_X_LO = 8'h44;
    localparam logic [7:0] IDX_RATE_Y_HI = 8'h45;
    localparam logic [7:0] IDX_RATE_Y_LO = 8'h46;
    localparam logic [7:0] IDX_RATE_Z_HI = 8'h47;
    localparam logic [7:0] IDX_RATE_Z_LO = 8'h48;
    localparam logic [7:0] IDX_PATH_RESTART = 8'h68;
    localparam logic [7:0] IDX_USER_CTRL = 8'h6a;
    localparam logic [7:0] IDX_NONE = 8'hff;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_WAKE_X = 7;
    localparam int BIT_WAKE_Y = 6;
    localparam int BIT_WAKE_Z = 5;
    localparam int BIT_OVERFLOW = 4;
    localparam int BIT_FLAG_RESVD = 3;
    localparam int BIT_DRIVE_RDY = 2;
    localparam int BIT_PROC_IRQ = 1;
    localparam int BIT_RAW_RDY = 0;
    localparam int BIT_RATE_RST = 2;
    localparam int BIT_ACCEL_RST = 1;
    localparam int BIT_TEMP_RST = 0;
    localparam int BIT_ANY_READ_CLR = 4;
    localparam int BIT_FULL_CLR = 0;

    // ----------------------------------------------------------------
    // masks and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] IRQ_FLAGS_MASK = 8'hf7;
    localparam logic [7:0] PIN_CFG_MASK = 8'h10;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_PIN_CFG = 8'h00;
    localparam logic [15:0] RST_SAMPLE = 16'h0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wake_x;
        logic wake_y;
        logic wake_z;
        logic buf_overflow;
        logic drive_ready;
        logic proc_irq;
    } msr_evt_t;

    typedef struct packed {
        logic signed [15:0] accel_x;
        logic signed [15:0] accel_y;
        logic signed [15:0] accel_z;
        logic signed [15:0] temp;
        logic signed [15:0] rate_x;
        logic signed [15:0] rate_y;
        logic signed [15:0] rate_z;
    } msr_sample_t;

    typedef struct packed {
        logic rate;
        logic accel;
        logic temp;
    } msr_path_rst_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b01,
        PH_WDATA = 2'b10
    } msr_phase_t;

endpackage

// File: testbench/msr_regs_tb.sv
`timescale 1ns/1ps
module msr_regs_tb;
    import msr_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    msr_evt_t evt;
    logic sample_valid;
    msr_sample_t sample;
    msr_path_rst_t path_rst;
    logic irq;
    int miscompares;
    int checked;
    logic [15:0] vals [7];
    logic [7:0] exp_f [6];

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    msr_regs #(.AW(ADDR_W)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .sample_valid(sample_valid),
        .sample(sample), .path_rst(path_rst), .irq(irq)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // bounded: a slave that never answers ends the run
    task automatic wait_ready();
        int n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                check("hready wait", {31'h0, hready}, 32'h1);
                report_and_stop();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic wr, input logic [7:0] wd,
                       output logic [31:0] rdata);
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_ready();
        rdata = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus({2'b00, idx, 2'b00}, 1'b1, d, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        bus({2'b00, idx, 2'b00}, 1'b0, 8'h00, r);
        check(what, r, {24'h0, exp});
    endtask

    task automatic pulse_evt(input msr_evt_t e);
        evt <= e;
        @(posedge hclk);
        evt <= '0;
        @(posedge hclk);
    endtask

    task automatic load_sample();
        sample <= {vals[0], vals[1], vals[2], vals[3], vals[4], vals[5], vals[6]};
        sample_valid <= 1'b1;
        @(posedge hclk);
        sample_valid <= 1'b0;
        @(posedge hclk);
    endtask

    // written value lands at the data-phase edge; the pulse stands one cycle after it
    task automatic restart_chk(input logic [7:0] idx, input logic [7:0] d, input logic [2:0] e);
        wr(idx, d);
        #1;
        check("path_rst pulse", {29'h0, path_rst}, {29'h0, e});
        @(posedge hclk);
        #1;
        check("path_rst after", {29'h0, path_rst}, 32'h0);
        @(posedge hclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        check("hreadyout", {31'h0, hreadyout}, 32'h1);
        check("hresp", {31'h0, hresp}, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        rd_chk("irq_flags rst", IDX_IRQ_FLAGS, 8'h00);
        rd_chk("rate_z_lo rst", IDX_RATE_Z_LO, 8'h00);
        rd_chk("path_restart rst", IDX_PATH_RESTART, 8'h00);
        $display("test reset done");
    endtask

    task automatic test_flags();
        for (int i = 0; i < 6; i++) begin
            pulse_evt(msr_evt_t'(6'h20 >> i));
            rd_chk("flag set", IDX_IRQ_FLAGS, exp_f[i]);
            rd_chk("flag cleared", IDX_IRQ_FLAGS, 8'h00);
        end
        pulse_evt(msr_evt_t'(6'h3f));
        wr(IDX_IRQ_FLAGS, 8'h00);
        rd_chk("all flags", IDX_IRQ_FLAGS, 8'hf6);
        $display("test flags done");
    endtask

    task automatic test_samples();
        for (int i = 0; i < 7; i++) begin
            vals[i] = {8'h80 + 8'(i * 17), 8'h01 + 8'(i * 3)};
        end
        load_sample();
        rd_chk("raw ready", IDX_IRQ_FLAGS, 8'h01);
        wr(IDX_ACCEL_X_HI, 8'h55);
        wr(IDX_RATE_Z_LO, 8'h55);
        for (int i = 0; i < 7; i++) begin
            rd_chk("sample hi", IDX_ACCEL_X_HI + 8'(2 * i), vals[i][15:8]);
            rd_chk("sample lo", IDX_ACCEL_X_LO + 8'(2 * i), vals[i][7:0]);
        end
        rd_chk("y hi", IDX_ACCEL_Y_HI, vals[1][15:8]);
        vals[1][7:0] = 8'h99;
        load_sample();
        rd_chk("y lo shadow", IDX_ACCEL_Y_LO, vals[0][7:0] + 8'h03);
        rd_chk("y lo live", IDX_ACCEL_Y_LO, 8'h99);
        $display("test samples done");
    endtask

    task automatic test_restart();
        restart_chk(IDX_PATH_RESTART, 8'h04, 3'b100);
        restart_chk(IDX_PATH_RESTART, 8'h02, 3'b010);
        restart_chk(IDX_PATH_RESTART, 8'h01, 3'b001);
        restart_chk(IDX_PATH_RESTART, 8'hf8, 3'b000);
        rd_chk("restart reads", IDX_PATH_RESTART, 8'h00);
        rd_chk("sample kept", IDX_ACCEL_X_HI, vals[0][15:8]);
        rd_chk("sample kept lo", IDX_RATE_Z_LO, vals[6][7:0]);
        $display("test restart done");
    endtask

    task automatic test_irq();
        logic [31:0] r;
        rd_chk("clear", IDX_IRQ_FLAGS, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h01);
        load_sample();
        #1;
        check("irq raw", {31'h0, irq}, 32'h1);
        @(posedge hclk);
        rd_chk("raw flag", IDX_IRQ_FLAGS, 8'h01);
        #1;
        check("irq dropped", {31'h0, irq}, 32'h0);
        @(posedge hclk);
        pulse_evt(msr_evt_t'(6'h04));
        repeat (2) @(posedge hclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(IDX_IRQ_ENABLE, 8'h10);
        repeat (2) @(posedge hclk);
        check("irq overflow", {31'h0, irq}, 32'h1);
        bus(12'h0e1, 1'b0, 8'h00, r);
        check("unmapped read", r, 32'h0);
        rd_chk("overflow flag", IDX_IRQ_FLAGS, 8'h10);
        $display("test irq done");
    endtask

    task automatic test_any_read();
        wr(IDX_PIN_CFG, 8'h10);
        rd_chk("pin cfg", IDX_PIN_CFG, 8'h10);
        pulse_evt(msr_evt_t'(6'h20));
        rd_chk("other read", IDX_TEMPERATURE_HI, vals[3][15:8]);
        rd_chk("any read cleared", IDX_IRQ_FLAGS, 8'h00);
        wr(IDX_PIN_CFG, 8'h00);
        pulse_evt(msr_evt_t'(6'h10));
        rd_chk("other read", IDX_TEMPERATURE_LO, vals[3][7:0]);
        rd_chk("kept by default", IDX_IRQ_FLAGS, 8'h40);
        sample_valid <= 1'b1;
        rd_chk("set and clear", IDX_IRQ_FLAGS, 8'h00);
        sample_valid <= 1'b0;
        rd_chk("set wins", IDX_IRQ_FLAGS, 8'h01);
        $display("test any read done");
    endtask

    task automatic test_full_clear();
        restart_chk(IDX_USER_CTRL, 8'h01, 3'b111);
        for (int i = 0; i < 14; i++) begin
            rd_chk("sample zero", IDX_ACCEL_X_HI + 8'(i), 8'h00);
        end
        rd_chk("user ctrl reads", IDX_USER_CTRL, 8'h00);
        $display("test full clear done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        evt = '0;
        sample_valid = 1'b0;
        sample = '0;
        miscompares = 0;
        checked = 0;
        exp_f = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_flags();
        test_samples();
        test_restart();
        test_irq();
        test_any_read();
        test_full_clear();
        report_and_stop();
    end
endmodule
